/* core/rxbb_consts.svh */
`ifndef RXBB_CONSTS_SVH
`define RXBB_CONSTS_SVH

// Register indices; byte address is four times the index
`define RXBB_IDX_CORNER 8'h38
`define RXBB_IDX_FACTOR 8'h39
`define RXBB_IDX_FSK 8'h3a
`define RXBB_IDX_ASK 8'h3b
`define RXBB_IDX_MATCHED 8'h3c
`define RXBB_IDX_RATE 8'h3d
`define RXBB_IDX_SLICER 8'h3e
`define RXBB_IDX_RUN 8'h3f
`define RXBB_IDX_WAKE 8'h40
`define RXBB_IDX_LOW 8'h41
`define RXBB_IDX_RANGE 8'h42
`define RXBB_IDX_NDCFG 8'h45
`define RXBB_IDX_POWER 8'h50
`define RXBB_IDX_STATUS 8'h51

// Reset values
`define RXBB_RST_CORNER 8'h07
`define RXBB_RST_FACTOR 8'h00
`define RXBB_RST_FSK 8'h00
`define RXBB_RST_ASK 8'h20
`define RXBB_RST_MATCHED 8'h07
`define RXBB_RST_RATE 8'h00
`define RXBB_RST_SLICER 8'h02
`define RXBB_RST_RUN 8'h00
`define RXBB_RST_WAKE 8'h00
`define RXBB_RST_LOW 8'h00
`define RXBB_RST_RANGE 8'h3f
`define RXBB_RST_NDCFG 8'h07

// Implemented bits of each register
`define RXBB_MSK_CORNER 8'h07
`define RXBB_MSK_FACTOR 8'h7f
`define RXBB_MSK_FSK 8'h3f
`define RXBB_MSK_ASK 8'h3f
`define RXBB_MSK_MATCHED 8'h0f
`define RXBB_MSK_RATE 8'hff
`define RXBB_MSK_SLICER 8'h1f
`define RXBB_MSK_FULL 8'hff
`define RXBB_MSK_RANGE 8'h3f

// Field positions
`define RXBB_CORNER_MSB 2
`define RXBB_FACTOR_MSB 6
`define RXBB_INTERP_BIT 5
`define RXBB_EXP_MSB 4
`define RXBB_MATCHED_MSB 3
`define RXBB_SLC_SCA_MSB 4
`define RXBB_SLC_SCA_LSB 3
`define RXBB_SLC_BW_MSB 2
`define RXBB_RNG_ASK_LSB 4
`define RXBB_RNG_FSK_LSB 2
`define RXBB_RNG_LOW_LSB 0
`define RXBB_COMBO_LSB 4

// Scaling and detector constants
`define RXBB_EXP_BIAS 10
`define RXBB_EXP_MAX 23
`define RXBB_COMBO_GATED 2'b11

`endif

/* core/rxbb_pkg.sv */
package rxbb_pkg;

	typedef enum logic [3:0] {
		SEL_CORNER = 4'b0000,
		SEL_FACTOR = 4'b0001,
		SEL_FSK = 4'b0010,
		SEL_ASK = 4'b0011,
		SEL_MATCHED = 4'b0100,
		SEL_RATE = 4'b0101,
		SEL_SLICER = 4'b0110,
		SEL_RUN = 4'b0111,
		SEL_WAKE = 4'b1000,
		SEL_LOW = 4'b1001,
		SEL_RANGE = 4'b1010,
		SEL_NDCFG = 4'b1011,
		SEL_POWER = 4'b1100,
		SEL_STATUS = 4'b1101,
		SEL_NONE = 4'b1111
	} reg_sel_t;

	typedef logic [11:0][7:0] regfile_t;

endpackage

/* core/stream_if.sv */
`timescale 1ns/100ps
interface stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* core/pow2_scaler.sv */
`timescale 1ns/100ps
`include "rxbb_consts.svh"
module pow2_scaler #(
	parameter int IN_W = 23,
	parameter int OUT_W = 16
) (
	// Operand
	input wire logic signed [IN_W-1:0] value,
	input wire logic [4:0] exponent,
	// Result
	output logic [OUT_W-1:0] scaled
);
	localparam int UP = `RXBB_EXP_MAX - `RXBB_EXP_BIAS;
	localparam int WW = IN_W + UP;
	logic [4:0] e;
	logic [4:0] sh;
	logic signed [WW-1:0] wide;
	logic signed [WW-1:0] shifted;
	logic fits;

	always_comb
	begin
		// Codes above the top step clamp rather than wrap
		e = (exponent > 5'(`RXBB_EXP_MAX)) ? 5'(`RXBB_EXP_MAX) : exponent;
		sh = 5'(`RXBB_EXP_MAX) - e;
		wide = {value, {UP{1'b0}}};
		shifted = wide >>> sh;
		fits = (&shifted[WW-1:OUT_W-1]) | ~(|shifted[WW-1:OUT_W-1]);
		// Saturate instead of wrapping at large gains
		if (fits)
			scaled = shifted[OUT_W-1:0];
		else
			scaled = {shifted[WW-1], {(OUT_W-1){~shifted[WW-1]}}};
	end
endmodule

/* core/pair_buffer.sv */
`timescale 1ns/100ps
module pair_buffer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Filling side
	stream_if.snk fill,
	// Draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic v0;
		logic v1;
		logic [W-1:0] d0;
		logic [W-1:0] d1;
	} buf_state_t;

	buf_state_t r;
	buf_state_t n;
	logic push;
	logic pop;

	assign fill.ready = ~r.v1;
	assign push = fill.valid & ~r.v1;
	assign pop = r.v0 & out_ready;
	assign out_valid = r.v0;
	assign out_data = r.d0;

	always_comb
	begin
		n = r;
		if (pop)
		begin
			n.d0 = r.d1;
			n.v0 = r.v1;
			n.v1 = 1'b0;
		end
		if (push)
		begin
			if (!n.v0)
			begin
				n.d0 = fill.data;
				n.v0 = 1'b1;
			end
			else
			begin
				n.d1 = fill.data;
				n.v1 = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			r <= '0;
		else
			r <= n;
	end
endmodule

/* core/rx_baseband_filter_sigdet_config.sv */
// Behaviour
// - Three-bit image filter corner code, 33 kHz at 0 to 282 kHz at 7, resets 7.
// - Pre-decimation divides by factor field plus one; zero means no decimation.
// - FSK mode scales decimator output by 2^(code-10), code 0 to 17h.
// - ASK mode uses its own five-bit scaling code over the same span.
// - Bit five of FSK scaling register enables FSK interpolation; resets off.
// - Bit five of ASK scaling register enables ASK interpolation; resets on.
// - Matched filter length is length field plus one; eight after reset.
// - Eight-bit rate converter tune word: 00h same rate, FFh half rate.
// - Two-bit slicer scaling selects 1/2, 1/4, 1/8, 1/16; resets 1/2.
// - Three-bit slicer manual bandwidth 1/8 to 1/48; codes 6,7 unused; resets 1/24.
// - Eight-bit run-mode detector threshold in its own register, resets zero.
// - Separate eight-bit wake-up detector threshold, resets zero.
// - Low threshold acts only when detector combination select is 11b.
// - ASK threshold scaled by 2^factor: 6, 7, 13 or 8; resets 8.
// - FSK threshold scaled by 2^factor: 2, 4, 6 or 8; resets 8.
// - Low threshold scaled by 2^factor: 2, 4, 6 or 8; resets 8.
// - In gated mode noise indication is valid only above the low threshold.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "rxbb_consts.svh"
module rx_baseband_filter_sigdet_config #(
	parameter int SAMPLE_W = 16,
	parameter int OUT_W = 16,
	parameter int POW_W = 24,
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Samples from the front-end converter
	input wire logic sample_valid,
	input wire logic signed [SAMPLE_W-1:0] sample_data,
	output logic sample_ready,
	// Decimated and scaled samples
	output logic out_valid,
	output logic [OUT_W-1:0] out_data,
	input wire logic out_ready,
	// Operating mode and detector inputs
	input wire logic ask_mode,
	input wire logic wakeup_mode,
	input wire logic [POW_W-1:0] signal_power,
	input wire logic noise_detect,
	// Detector results
	output logic signal_detect,
	output logic low_level_detect,
	output logic noise_detect_valid,
	// Configuration for the rest of the chain
	output logic [2:0] image_corner_code,
	output logic [7:0] decimation_ratio,
	output logic fsk_interp_enable,
	output logic ask_interp_enable,
	output logic [4:0] matched_length,
	output logic [7:0] rate_converter_tune_word,
	output logic [1:0] slicer_bw_scaling,
	output logic [2:0] slicer_manual_bw
);
	localparam int ACC_W = SAMPLE_W + 7;
	localparam int THR_W = 21;
	localparam rxbb_pkg::regfile_t REG_RST = {
		`RXBB_RST_NDCFG, `RXBB_RST_RANGE, `RXBB_RST_LOW, `RXBB_RST_WAKE,
		`RXBB_RST_RUN, `RXBB_RST_SLICER, `RXBB_RST_RATE, `RXBB_RST_MATCHED,
		`RXBB_RST_ASK, `RXBB_RST_FSK, `RXBB_RST_FACTOR, `RXBB_RST_CORNER};

	typedef struct packed {
		rxbb_pkg::regfile_t regs;
		logic [7:0] rdata;
		logic waitreq;
		logic signed [ACC_W-1:0] acc;
		logic [6:0] cnt;
		logic stage_valid;
		logic [OUT_W-1:0] stage_data;
		logic in_ready;
		logic [POW_W-1:0] power;
		logic noise_in;
		logic sig_det;
		logic low_det;
		logic noise_val;
		logic [4:0] mf_len;
		logic [7:0] dec_ratio;
	} state_t;

	localparam state_t STATE_RST = '{
		regs: REG_RST, rdata: 8'h00, waitreq: 1'b1, acc: '0, cnt: 7'h00,
		stage_valid: 1'b0, stage_data: '0, in_ready: 1'b0, power: '0,
		noise_in: 1'b0, sig_det: 1'b0, low_det: 1'b0, noise_val: 1'b0,
		mf_len: 5'h08, dec_ratio: 8'h01};

	state_t r;
	state_t n;
	logic signed [ACC_W-1:0] acc_sum;
	logic [4:0] exponent;
	logic [OUT_W-1:0] scaled;

	stream_if #(.W(OUT_W)) stage_if ();

	function automatic rxbb_pkg::reg_sel_t reg_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = 8'(a >> 2);
		if (a[1:0] != 2'b00)
			return rxbb_pkg::SEL_NONE;
		unique case (idx)
			`RXBB_IDX_CORNER: return rxbb_pkg::SEL_CORNER;
			`RXBB_IDX_FACTOR: return rxbb_pkg::SEL_FACTOR;
			`RXBB_IDX_FSK: return rxbb_pkg::SEL_FSK;
			`RXBB_IDX_ASK: return rxbb_pkg::SEL_ASK;
			`RXBB_IDX_MATCHED: return rxbb_pkg::SEL_MATCHED;
			`RXBB_IDX_RATE: return rxbb_pkg::SEL_RATE;
			`RXBB_IDX_SLICER: return rxbb_pkg::SEL_SLICER;
			`RXBB_IDX_RUN: return rxbb_pkg::SEL_RUN;
			`RXBB_IDX_WAKE: return rxbb_pkg::SEL_WAKE;
			`RXBB_IDX_LOW: return rxbb_pkg::SEL_LOW;
			`RXBB_IDX_RANGE: return rxbb_pkg::SEL_RANGE;
			`RXBB_IDX_NDCFG: return rxbb_pkg::SEL_NDCFG;
			`RXBB_IDX_POWER: return rxbb_pkg::SEL_POWER;
			`RXBB_IDX_STATUS: return rxbb_pkg::SEL_STATUS;
			default: return rxbb_pkg::SEL_NONE;
		endcase
	endfunction

	// Only implemented bits survive a write or show on a read
	function automatic logic [7:0] reg_mask(input rxbb_pkg::reg_sel_t s);
		unique case (s)
			rxbb_pkg::SEL_CORNER: return `RXBB_MSK_CORNER;
			rxbb_pkg::SEL_FACTOR: return `RXBB_MSK_FACTOR;
			rxbb_pkg::SEL_FSK: return `RXBB_MSK_FSK;
			rxbb_pkg::SEL_ASK: return `RXBB_MSK_ASK;
			rxbb_pkg::SEL_MATCHED: return `RXBB_MSK_MATCHED;
			rxbb_pkg::SEL_RATE: return `RXBB_MSK_RATE;
			rxbb_pkg::SEL_SLICER: return `RXBB_MSK_SLICER;
			rxbb_pkg::SEL_RUN: return `RXBB_MSK_FULL;
			rxbb_pkg::SEL_WAKE: return `RXBB_MSK_FULL;
			rxbb_pkg::SEL_LOW: return `RXBB_MSK_FULL;
			rxbb_pkg::SEL_RANGE: return `RXBB_MSK_RANGE;
			rxbb_pkg::SEL_NDCFG: return `RXBB_MSK_FULL;
			default: return 8'h00;
		endcase
	endfunction

	// Factor 2, 4, 6 or 8 shared by the FSK and low ranges
	function automatic logic [3:0] even_range(input logic [1:0] code);
		return {1'b0, code, 1'b0} + 4'h2;
	endfunction

	function automatic logic [3:0] ask_range(input logic [1:0] code);
		unique case (code)
			2'b00: return 4'h6;
			2'b01: return 4'h7;
			2'b10: return 4'hd;
			2'b11: return 4'h8;
		endcase
	endfunction

	assign acc_sum = r.acc + ACC_W'(sample_data);
	// Exponent follows the active modulation
	assign exponent = ask_mode ?
		r.regs[rxbb_pkg::SEL_ASK][`RXBB_EXP_MSB:0] :
		r.regs[rxbb_pkg::SEL_FSK][`RXBB_EXP_MSB:0];

	pow2_scaler #(.IN_W(ACC_W), .OUT_W(OUT_W)) u_scaler (
		.value(acc_sum),
		.exponent(exponent),
		.scaled(scaled)
	);

	assign stage_if.valid = r.stage_valid;
	assign stage_if.data = r.stage_data;

	pair_buffer #(.W(OUT_W)) u_buffer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.fill(stage_if),
		.out_valid(out_valid),
		.out_data(out_data),
		.out_ready(out_ready)
	);

	always_comb
	begin
		rxbb_pkg::reg_sel_t sel;
		logic [7:0] thr;
		logic [3:0] rng;
		logic [3:0] low_rng;
		logic [THR_W-1:0] thr_s;
		logic [THR_W-1:0] low_s;
		logic above_low;
		sel = reg_decode(address);
		thr = 8'h00;
		rng = 4'h0;
		low_rng = 4'h0;
		thr_s = '0;
		low_s = '0;
		above_low = 1'b0;
		n = r;

		// One wait cycle, then a one-cycle answer
		n.waitreq = 1'b1;
		if ((read || write) && r.waitreq)
		begin
			n.waitreq = 1'b0;
			unique case (sel)
				rxbb_pkg::SEL_POWER: n.rdata = r.power[POW_W-1 -: 8];
				rxbb_pkg::SEL_STATUS: n.rdata = {5'h00, r.noise_val, r.low_det, r.sig_det};
				rxbb_pkg::SEL_NONE: n.rdata = 8'h00;
				default: n.rdata = r.regs[sel] & reg_mask(sel);
			endcase
		end
		if (write && !r.waitreq && byteenable[0] && (sel <= rxbb_pkg::SEL_NDCFG))
			n.regs[sel] = writedata[7:0] & reg_mask(sel);

		// Decimating accumulator; stage drains into the buffer
		if (r.stage_valid && stage_if.ready)
			n.stage_valid = 1'b0;
		if (sample_valid && r.in_ready)
		begin
			if (r.cnt >= r.regs[rxbb_pkg::SEL_FACTOR][`RXBB_FACTOR_MSB:0])
			begin
				n.stage_data = scaled;
				n.stage_valid = 1'b1;
				n.acc = '0;
				n.cnt = 7'h00;
			end
			else
			begin
				n.acc = acc_sum;
				n.cnt = r.cnt + 7'h01;
			end
		end
		// Registered ready costs a bubble per output word
		n.in_ready = ~n.stage_valid;

		n.dec_ratio = {1'b0, r.regs[rxbb_pkg::SEL_FACTOR][`RXBB_FACTOR_MSB:0]} + 8'h01;
		n.mf_len = {1'b0, r.regs[rxbb_pkg::SEL_MATCHED][`RXBB_MATCHED_MSB:0]} + 5'h01;

		// Signal detector
		n.power = signal_power;
		n.noise_in = noise_detect;
		thr = wakeup_mode ? r.regs[rxbb_pkg::SEL_WAKE] : r.regs[rxbb_pkg::SEL_RUN];
		if (ask_mode)
			rng = ask_range(r.regs[rxbb_pkg::SEL_RANGE][`RXBB_RNG_ASK_LSB +: 2]);
		else
			rng = even_range(r.regs[rxbb_pkg::SEL_RANGE][`RXBB_RNG_FSK_LSB +: 2]);
		low_rng = even_range(r.regs[rxbb_pkg::SEL_RANGE][`RXBB_RNG_LOW_LSB +: 2]);
		thr_s = THR_W'(thr) << rng;
		low_s = THR_W'(r.regs[rxbb_pkg::SEL_LOW]) << low_rng;
		above_low = r.power > POW_W'(low_s);
		n.sig_det = r.power > POW_W'(thr_s);
		if (r.regs[rxbb_pkg::SEL_NDCFG][`RXBB_COMBO_LSB +: 2] == `RXBB_COMBO_GATED)
		begin
			n.low_det = above_low;
			n.noise_val = r.noise_in & above_low;
		end
		else
		begin
			n.low_det = 1'b0;
			n.noise_val = r.noise_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			r <= STATE_RST;
		else
			r <= n;
	end

	assign readdata = {24'h00_0000, r.rdata};
	assign waitrequest = r.waitreq;
	assign sample_ready = r.in_ready;
	assign signal_detect = r.sig_det;
	assign low_level_detect = r.low_det;
	assign noise_detect_valid = r.noise_val;
	assign image_corner_code = r.regs[rxbb_pkg::SEL_CORNER][`RXBB_CORNER_MSB:0];
	assign decimation_ratio = r.dec_ratio;
	assign fsk_interp_enable = r.regs[rxbb_pkg::SEL_FSK][`RXBB_INTERP_BIT];
	assign ask_interp_enable = r.regs[rxbb_pkg::SEL_ASK][`RXBB_INTERP_BIT];
	assign matched_length = r.mf_len;
	assign rate_converter_tune_word = r.regs[rxbb_pkg::SEL_RATE];
	// Unused bandwidth codes are stored and passed on unchanged
	assign slicer_bw_scaling = r.regs[rxbb_pkg::SEL_SLICER][`RXBB_SLC_SCA_MSB:`RXBB_SLC_SCA_LSB];
	assign slicer_manual_bw = r.regs[rxbb_pkg::SEL_SLICER][`RXBB_SLC_BW_MSB:0];
endmodule

/* dv/config_monitor.sv */
`timescale 1ns/100ps
module config_monitor #(
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Stream and detector
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic noise_detect,
	input wire logic noise_detect_valid,
	// Configuration
	input wire logic [2:0] image_corner_code,
	input wire logic [7:0] decimation_ratio,
	input wire logic fsk_interp_enable,
	input wire logic ask_interp_enable,
	input wire logic [4:0] matched_length,
	input wire logic [7:0] rate_converter_tune_word,
	input wire logic [1:0] slicer_bw_scaling,
	input wire logic [2:0] slicer_manual_bw
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	logic wa;
	assign wa = write & ~waitrequest & byteenable[0];
	chk_corner_write: assert property (wa && address == 10'h0e0 |=>
		image_corner_code == $past(writedata[2:0])) else $error("corner not loaded");
	chk_ratio_write: assert property (wa && address == 10'h0e4 |=> ##1
		decimation_ratio == {1'b0, $past(writedata[6:0], 2)} + 8'h01) else $error("bad ratio");
	chk_fsk_interp: assert property (wa && address == 10'h0e8 |=>
		fsk_interp_enable == $past(writedata[5])) else $error("fsk interp wrong");
	chk_ask_interp: assert property (wa && address == 10'h0ec |=>
		ask_interp_enable == $past(writedata[5])) else $error("ask interp wrong");
	chk_length_write: assert property (wa && address == 10'h0f0 |=> ##1
		matched_length == {1'b0, $past(writedata[3:0], 2)} + 5'h01) else $error("bad length");
	chk_tune_write: assert property (wa && address == 10'h0f4 |=>
		rate_converter_tune_word == $past(writedata[7:0])) else $error("tune wrong");
	chk_slicer_write: assert property (wa && address == 10'h0f8 |=>
		{slicer_bw_scaling, slicer_manual_bw} == $past(writedata[4:0])) else $error("slicer wrong");
	chk_reset_values: assert property ($rose(rstn) |-> image_corner_code == 3'h7
		&& decimation_ratio == 8'h01 && matched_length == 5'h08 && !fsk_interp_enable
		&& ask_interp_enable && slicer_manual_bw == 3'h2) else $error("reset value wrong");
	chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_noise_gate: assert property (noise_detect_valid |->
		$past(noise_detect) || $past(noise_detect, 2)) else $error("noise valid without noise");
	cover property (wa && address == 10'h0e4);
	cover property (out_valid && !out_ready ##1 out_valid);
	cover property (noise_detect && !noise_detect_valid);
endmodule

/* dv/frontend_model.sv */
`timescale 1ns/100ps
module frontend_model #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Control
	input wire logic run,
	// Samples
	output logic sample_valid,
	output logic signed [W-1:0] sample_data,
	input wire logic sample_ready
);
	// Random gaps give both prompt and slow delivery; idle data toggles
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			sample_valid <= 1'b0;
			sample_data <= '0;
		end
		else if (!sample_valid || sample_ready)
		begin
			if (run && $urandom_range(3) != 0)
			begin
				sample_valid <= 1'b1;
				sample_data <= W'($urandom_range(1023));
			end
			else
			begin
				sample_valid <= 1'b0;
				sample_data <= ~sample_data;
			end
		end
endmodule

/* dv/rx_baseband_filter_sigdet_config_test.sv */
`timescale 1ns/100ps
`include "rxbb_consts.svh"
module rx_baseband_filter_sigdet_config_test;
	logic sys_clk = 0, rstn = 0, read = 0, write = 0, out_ready = 0, ask_mode = 0;
	logic wakeup_mode = 0, noise_detect = 0, run = 0, waitrequest, sample_valid, sample_ready;
	logic out_valid, signal_detect, low_level_detect, noise_detect_valid;
	logic fsk_interp_enable, ask_interp_enable;
	logic [9:0] address = '0;
	logic [31:0] writedata = '0, readdata;
	logic [3:0] byteenable = 4'h1;
	logic signed [15:0] sample_data;
	logic [15:0] out_data;
	logic [23:0] signal_power = '0;
	logic [2:0] image_corner_code, slicer_manual_bw;
	logic [7:0] decimation_ratio, rate_converter_tune_word, t, d, rg, nd, ex;
	logic [4:0] matched_length;
	logic [1:0] slicer_bw_scaling;
	int errors = 0, samples_checked = 0, sf, se, nout, thr, lo, pw;
	int q[$];
	int ids[12] = '{'h38, 'h39, 'h3a, 'h3b, 'h3c, 'h3d, 'h3e, 'h3f, 'h40, 'h41, 'h42, 'h45};
	int ash[4] = '{6, 7, 13, 8};
	int fsh[4] = '{2, 4, 6, 8};
	logic [7:0] regs[12];
	logic [7:0] rst[12] = '{`RXBB_RST_CORNER, `RXBB_RST_FACTOR, `RXBB_RST_FSK, `RXBB_RST_ASK,
		`RXBB_RST_MATCHED, `RXBB_RST_RATE, `RXBB_RST_SLICER, `RXBB_RST_RUN, `RXBB_RST_WAKE,
		`RXBB_RST_LOW, `RXBB_RST_RANGE, `RXBB_RST_NDCFG};
	logic [7:0] msk[12] = '{`RXBB_MSK_CORNER, `RXBB_MSK_FACTOR, `RXBB_MSK_FSK, `RXBB_MSK_ASK,
		`RXBB_MSK_MATCHED, `RXBB_MSK_RATE, `RXBB_MSK_SLICER, `RXBB_MSK_FULL, `RXBB_MSK_FULL,
		`RXBB_MSK_FULL, `RXBB_MSK_RANGE, `RXBB_MSK_FULL};
	longint s;

	rx_baseband_filter_sigdet_config rx_baseband_filter_sigdet_config_i (
		.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .out_valid(out_valid), .out_data(out_data),
		.out_ready(out_ready), .ask_mode(ask_mode), .wakeup_mode(wakeup_mode),
		.signal_power(signal_power), .noise_detect(noise_detect), .signal_detect(signal_detect),
		.low_level_detect(low_level_detect), .noise_detect_valid(noise_detect_valid),
		.image_corner_code(image_corner_code), .decimation_ratio(decimation_ratio),
		.fsk_interp_enable(fsk_interp_enable), .ask_interp_enable(ask_interp_enable),
		.matched_length(matched_length), .rate_converter_tune_word(rate_converter_tune_word),
		.slicer_bw_scaling(slicer_bw_scaling), .slicer_manual_bw(slicer_manual_bw));
	frontend_model frontend_model_i (
		.sys_clk(sys_clk), .rstn(rstn), .run(run), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_ready(sample_ready));

	always #2.5 sys_clk = ~sys_clk;

	task cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Waits on waitrequest only; the watchdog catches a dead slave
	task bus(input logic w, input int a, input logic [7:0] v, output logic [7:0] r);
		@(posedge sys_clk);
		address <= 10'(a);
		writedata <= 32'(v);
		write <= w;
		read <= !w;
		do
			@(posedge sys_clk);
		while (waitrequest !== 1'b0);
		r = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task wr(input int i, input logic [7:0] v);
		bus(1'b1, i * 4, v, t);
	endtask

	task rdc(input int i, input logic [7:0] e);
		bus(1'b0, i * 4, 8'h00, t);
		cmp(32'(t), 32'(e));
	endtask

	task cfgchk;
		cmp({image_corner_code, decimation_ratio, fsk_interp_enable, ask_interp_enable,
			matched_length, rate_converter_tune_word, slicer_bw_scaling, slicer_manual_bw},
			{regs[0][2:0], 8'(regs[1][6:0]) + 8'h01, regs[2][5], regs[3][5],
			5'(regs[4][3:0]) + 5'h01, regs[5], regs[6][4:3], regs[6][2:0]});
	endtask

	// Second reset clears any partial group so each phase starts aligned
	task stream(input int f, input int e, input logic am);
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		q.delete();
		nout = 0;
		sf = f;
		se = e;
		wr('h39, 8'(f));
		wr(am ? 'h3b : 'h3a, 8'(e));
		ask_mode <= am;
		run <= 1'b1;
		repeat (300)
		begin
			@(posedge sys_clk);
			out_ready <= 1'($urandom_range(1));
		end
		out_ready <= 1'b0;
		repeat (20) @(posedge sys_clk);
		run <= 1'b0;
		out_ready <= 1'b1;
		repeat (40) @(posedge sys_clk);
		cmp(32'(q.size() <= f && nout > 0), 32'h1);
		$display("stream factor %0d exponent %0d done", f, e);
	endtask

	always @(posedge sys_clk)
		if (rstn && sample_valid === 1'b1 && sample_ready === 1'b1)
			q.push_back(sample_data);

	always @(posedge sys_clk)
		if (rstn && out_valid === 1'b1 && out_ready === 1'b1)
		begin
			s = 0;
			repeat (sf + 1) s += q.size() ? q.pop_front() : 0;
			s = s <<< (se - 10);
			if (s > 32767)
				s = 32767;
			cmp(32'(out_data), 32'(s[15:0]));
			nout++;
		end

	task conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Far above the sixteen hundred or so cycles the tests need
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		conclude;
	end

	initial
	begin
		void'($urandom(88527));
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (ids[i])
		begin
			rdc(ids[i], rst[i]);
			regs[i] = rst[i];
		end
		cfgchk;
		foreach (ids[i])
		begin
			d = 8'($urandom);
			wr(ids[i], d);
			regs[i] = d & msk[i];
			rdc(ids[i], regs[i]);
		end
		cfgchk;
		byteenable <= 4'h0;
		wr('h3c, ~regs[4]);
		byteenable <= 4'h1;
		rdc('h3c, regs[4]);
		bus(1'b1, 'h3fc, 8'hff, t);
		rdc('hff, 8'h00);
		bus(1'b0, 'h0e1, 8'h00, t);
		cmp(32'(t), 32'h0);
		$display("registers done");
		wr('h3f, 8'h10);
		wr('h40, 8'h03);
		wr('h41, 8'h05);
		repeat (24)
		begin
			rg = 8'($urandom) & 8'h3f;
			nd = $urandom_range(1) ? 8'h30 : 8'h07;
			wr('h42, rg);
			wr('h45, nd);
			d = 8'($urandom);
			thr = (d[1] ? 3 : 16) << (d[0] ? ash[rg[5:4]] : fsh[rg[3:2]]);
			lo = 5 << fsh[rg[1:0]];
			pw = (d[3] ? thr : lo) + $urandom_range(2) - 1;
			ask_mode <= d[0];
			wakeup_mode <= d[1];
			noise_detect <= d[2];
			signal_power <= 24'(pw);
			repeat (4) @(posedge sys_clk);
			ex = {5'h00, d[2] && (nd != 8'h30 || pw > lo), nd == 8'h30 && pw > lo, pw > thr};
			cmp({signal_detect, low_level_detect, noise_detect_valid},
				{ex[0], ex[1], ex[2]});
			rdc('h50, 8'(pw >> 16));
			rdc('h51, ex);
		end
		$display("detectors done");
		stream(3, 'h0b, 1'b0);
		stream(0, 'h17, 1'b1);
		stream(127, 'h0a, 1'b0);
		conclude;
	end
endmodule

bind rx_baseband_filter_sigdet_config config_monitor #(.ADDR_W(ADDR_W)) config_monitor_i (
	.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .out_valid(out_valid), .out_ready(out_ready),
	.noise_detect(noise_detect), .noise_detect_valid(noise_detect_valid),
	.image_corner_code(image_corner_code), .decimation_ratio(decimation_ratio),
	.fsk_interp_enable(fsk_interp_enable), .ask_interp_enable(ask_interp_enable),
	.matched_length(matched_length), .rate_converter_tune_word(rate_converter_tune_word),
	.slicer_bw_scaling(slicer_bw_scaling), .slicer_manual_bw(slicer_manual_bw));
